// *** src/cacr_regs.sv ***
// Auxiliary pin control, clock source selection and left attack time
// registers. Assumes a simple synchronous 8-bit register port from the
// control bus front end (I2C or SPI), with one-cycle read and write
// strobes, and pins already synchronous to ref_clk.
`timescale 1ns/10ps
module cacr_regs
    import cacr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    // Register port
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Control bus select: 0 is I2C mode
    input wire logic bus_select,
    // Multifunction pins
    input wire logic multi_pin_zero_in,
    input wire logic multi_pin_one_in,
    input wire logic multi_pin_three_in,
    output logic multi_pin_two_out,
    output logic multi_pin_two_oe,
    output logic audio_serial_in_en,
    output logic multi_pin_three_gpi_en,
    // Clock control outputs
    output logic core_clock_sel_div,
    output logic [1:0] clock_divider_input_sel,
    output logic [1:0] pll_input_clock_sel,
    output logic [4:0] pll_divider_n,
    // Left auto_gain_control attack control
    output logic atk_from_new_reg,
    output logic [3:0] atk_base_ms,
    output logic [7:0] atk_multiplier
);
    import cacr_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] aux_r, aux_nxt;
    logic [7:0] clk_r, clk_nxt;
    logic [7:0] atk_r, atk_nxt;
    logic [1:0] addr_pins_r, addr_pins_nxt;
    logic strap_done_r, strap_done_nxt;
    logic gpi_r, gpi_nxt;
    logic [7:0] rdata_nxt;
    logic i2c_mode;

    assign i2c_mode = (bus_select == 1'b0);

    always_comb
    begin
        aux_nxt = aux_r;
        clk_nxt = clk_r;
        atk_nxt = atk_r;
        addr_pins_nxt = addr_pins_r;
        strap_done_nxt = 1'b1;
        gpi_nxt = gpi_r;
        // Straps taken in the first cycle after reset, never again
        if (!strap_done_r)
        begin
            addr_pins_nxt = {multi_pin_zero_in, multi_pin_one_in};
        end
        // Pin level only tracked while the input use is enabled
        if (aux_r[CACR_AUX_GPI_EN_BIT] && i2c_mode)
        begin
            gpi_nxt = multi_pin_three_in;
        end
        if (reg_wr)
        begin
            unique case (reg_addr)
                CACR_AUX_PIN_ADDR:
                begin
                    // Read-only bits 7, 6, 3 keep their zero storage
                    aux_nxt = reg_wdata & CACR_AUX_WR_MASK;
                end
                CACR_CLK_SRC_ADDR:
                begin
                    // Reserved code 11 is stored as written; see note
                    clk_nxt = reg_wdata;
                end
                CACR_AGC_ATK_ADDR:
                begin
                    atk_nxt = reg_wdata & CACR_ATK_WR_MASK;
                end
                default:
                begin
                    aux_nxt = aux_r;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            aux_r <= CACR_AUX_RESET;
            clk_r <= CACR_CLK_RESET;
            atk_r <= CACR_ATK_RESET;
            addr_pins_r <= 2'b00;
            strap_done_r <= 1'b0;
            gpi_r <= 1'b0;
        end
        else
        begin
            aux_r <= aux_nxt;
            clk_r <= clk_nxt;
            atk_r <= atk_nxt;
            addr_pins_r <= addr_pins_nxt;
            strap_done_r <= strap_done_nxt;
            gpi_r <= gpi_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = reg_rdata;
        if (reg_rd)
        begin
            unique case (reg_addr)
                CACR_AUX_PIN_ADDR:
                begin
                    rdata_nxt = aux_r;
                    // Address bit zero lives on pin one, bit one on pin zero
                    rdata_nxt[CACR_AUX_ADDR0_BIT] = addr_pins_r[0];
                    rdata_nxt[CACR_AUX_ADDR1_BIT] = addr_pins_r[1];
                    rdata_nxt[CACR_AUX_GPI_VAL_BIT] = gpi_r;
                end
                CACR_CLK_SRC_ADDR:
                begin
                    rdata_nxt = clk_r;
                end
                CACR_AGC_ATK_ADDR:
                begin
                    rdata_nxt = atk_r;
                end
                default:
                begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= rdata_nxt;
        end
    end

    assign reg_hit = (reg_addr == CACR_AUX_PIN_ADDR) ||
        (reg_addr == CACR_CLK_SRC_ADDR) || (reg_addr == CACR_AGC_ATK_ADDR);

    // ------------------------------------------------------------
    // Pin controls, gated to I2C mode
    // ------------------------------------------------------------
    // In SPI mode the pins belong to the bus, so every use is dropped
    assign multi_pin_three_gpi_en =
        i2c_mode && aux_r[CACR_AUX_GPI_EN_BIT];
    assign audio_serial_in_en =
        i2c_mode && aux_r[CACR_AUX_SDI_EN_BIT];
    assign multi_pin_two_oe =
        i2c_mode && aux_r[CACR_AUX_GPO_EN_BIT];
    assign multi_pin_two_out = multi_pin_two_oe &&
        aux_r[CACR_AUX_GPO_VAL_BIT];

    // ------------------------------------------------------------
    // Clock and attack controls
    // ------------------------------------------------------------
    assign core_clock_sel_div = aux_r[CACR_AUX_CORE_SEL_BIT];
    assign clock_divider_input_sel =
        clk_r[CACR_DIV_SRC_LSB +: 2];
    assign pll_input_clock_sel = clk_r[CACR_PLL_SRC_LSB +: 2];

    always_comb
    begin
        unique case (clk_r[CACR_PLL_N_LSB +: CACR_PLL_N_W])
            CACR_N_CODE_16: pll_divider_n = CACR_N_VAL_16;
            CACR_N_CODE_17: pll_divider_n = CACR_N_VAL_17;
            default: pll_divider_n = {1'b0, clk_r[CACR_PLL_N_LSB +: 4]};
        endcase
    end

    assign atk_from_new_reg = atk_r[CACR_ATK_SEL_BIT];

    always_comb
    begin
        unique case (atk_r[CACR_ATK_BASE_LSB +: 2])
            2'h0: atk_base_ms = CACR_ATK_MS_0;
            2'h1: atk_base_ms = CACR_ATK_MS_1;
            2'h2: atk_base_ms = CACR_ATK_MS_2;
            default: atk_base_ms = CACR_ATK_MS_3;
        endcase
    end

    assign atk_multiplier =
        8'h01 << atk_r[CACR_ATK_MUL_LSB +: 3];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_strap_hold;
        @(posedge ref_clk) disable iff (srst)
        strap_done_r |=> $stable(addr_pins_r);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("address status changed after capture");

    property p_strap_take;
        @(posedge ref_clk) disable iff (srst)
        !strap_done_r |=>
            addr_pins_r == $past({multi_pin_zero_in, multi_pin_one_in});
    endproperty
    a_strap_take: assert property (p_strap_take)
        else $error("address status not captured at release");

    property p_spi_gates;
        @(posedge ref_clk) disable iff (srst)
        bus_select |-> !multi_pin_two_oe && !audio_serial_in_en &&
            !multi_pin_three_gpi_en;
    endproperty
    a_spi_gates: assert property (p_spi_gates)
        else $error("pin use active in SPI mode");

    property p_gpo_level;
        @(posedge ref_clk) disable iff (srst)
        (reg_wr && reg_addr == CACR_AUX_PIN_ADDR && !bus_select &&
            reg_wdata[2:1] == 2'b11) ##1 !bus_select |->
            multi_pin_two_oe && multi_pin_two_out;
    endproperty
    a_gpo_level: assert property (p_gpo_level)
        else $error("pin two not driven high");

    property p_aux_ro;
        @(posedge ref_clk) disable iff (srst)
        (reg_wr && reg_addr == CACR_AUX_PIN_ADDR) |=>
            aux_r[7:6] == 2'b00 && aux_r[3] == 1'b0;
    endproperty
    a_aux_ro: assert property (p_aux_ro)
        else $error("read-only bit took a write");

    property p_pll_n;
        @(posedge ref_clk) disable iff (srst)
        (reg_wr && reg_addr == CACR_CLK_SRC_ADDR &&
            reg_wdata[3:0] == 4'h0) |=> pll_divider_n == 5'h10;
    endproperty
    a_pll_n: assert property (p_pll_n)
        else $error("PLL N for code zero is not 16");

    property p_clk_sel;
        @(posedge ref_clk) disable iff (srst)
        (reg_wr && reg_addr == CACR_CLK_SRC_ADDR) |=>
            clock_divider_input_sel == $past(reg_wdata[7:6]) &&
            pll_input_clock_sel == $past(reg_wdata[5:4]);
    endproperty
    a_clk_sel: assert property (p_clk_sel)
        else $error("clock source select not updated");

    property p_atk;
        @(posedge ref_clk) disable iff (srst)
        (reg_wr && reg_addr == CACR_AGC_ATK_ADDR &&
            reg_wdata[4:2] == 3'h7 && reg_wdata[6:5] == 2'h0) |=>
            atk_multiplier == 8'h80 && atk_base_ms == 4'h7;
    endproperty
    a_atk: assert property (p_atk)
        else $error("attack time fields decoded wrongly");

    property p_core_sel;
        @(posedge ref_clk) disable iff (srst)
        (reg_wr && reg_addr == CACR_AUX_PIN_ADDR) |=>
            core_clock_sel_div == $past(reg_wdata[0]);
    endproperty
    a_core_sel: assert property (p_core_sel)
        else $error("core clock select not updated");

endmodule

// *** include/cacr_pkg.sv ***
// Constants for the codec auxiliary pin, clock source and left attack
// register block. Assumes an 8-bit register port with 7-bit addresses.
package cacr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] CACR_AUX_PIN_ADDR = 7'h65;
    localparam logic [6:0] CACR_CLK_SRC_ADDR = 7'h66;
    localparam logic [6:0] CACR_AGC_ATK_ADDR = 7'h67;

    // ------------------------------------------------------------
    // Auxiliary pin register fields
    // ------------------------------------------------------------
    localparam int CACR_AUX_ADDR0_BIT = 7;
    localparam int CACR_AUX_ADDR1_BIT = 6;
    localparam int CACR_AUX_GPI_EN_BIT = 5;
    localparam int CACR_AUX_SDI_EN_BIT = 4;
    localparam int CACR_AUX_GPI_VAL_BIT = 3;
    localparam int CACR_AUX_GPO_EN_BIT = 2;
    localparam int CACR_AUX_GPO_VAL_BIT = 1;
    localparam int CACR_AUX_CORE_SEL_BIT = 0;
    // Writable bits of the auxiliary pin register
    localparam logic [7:0] CACR_AUX_WR_MASK = 8'h37;
    localparam logic [7:0] CACR_AUX_RESET = 8'h00;

    // ------------------------------------------------------------
    // Clock source register fields
    // ------------------------------------------------------------
    localparam int CACR_DIV_SRC_LSB = 6;
    localparam int CACR_PLL_SRC_LSB = 4;
    localparam int CACR_PLL_N_LSB = 0;
    localparam int CACR_PLL_N_W = 4;
    localparam logic [7:0] CACR_CLK_RESET = 8'h02;
    localparam logic [3:0] CACR_N_CODE_16 = 4'h0;
    localparam logic [3:0] CACR_N_CODE_17 = 4'h1;
    localparam logic [4:0] CACR_N_VAL_16 = 5'h10;
    localparam logic [4:0] CACR_N_VAL_17 = 5'h11;

    // Clock source selections (code 11 is reserved)
    typedef enum logic [1:0] {
        CACR_SRC_MCLK = 2'b00,
        CACR_SRC_GP2 = 2'b01,
        CACR_SRC_BCLK = 2'b10,
        CACR_SRC_RSVD = 2'b11
    } cacr_src_e;

    // ------------------------------------------------------------
    // Left attack register fields
    // ------------------------------------------------------------
    localparam int CACR_ATK_SEL_BIT = 7;
    localparam int CACR_ATK_BASE_LSB = 5;
    localparam int CACR_ATK_MUL_LSB = 2;
    localparam logic [7:0] CACR_ATK_RESET = 8'h00;
    localparam logic [7:0] CACR_ATK_WR_MASK = 8'hFC;

    // Baseline attack times in ms
    localparam logic [3:0] CACR_ATK_MS_0 = 4'h7;
    localparam logic [3:0] CACR_ATK_MS_1 = 4'h8;
    localparam logic [3:0] CACR_ATK_MS_2 = 4'hA;
    localparam logic [3:0] CACR_ATK_MS_3 = 4'hB;

endpackage

// *** tb/cacr_host.sv ***
// Host model driving the register port of the pin and clock block.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/10ps
module cacr_host
    import cacr_pkg::*;
(
    input wire logic ref_clk,
    output logic [6:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 7'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // A free edge first, so two strobes never merge into one
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_wdata = (a == CACR_AGC_ATK_ADDR) ?
            (d & CACR_ATK_WR_MASK) : d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        // Released data must not keep showing the last byte
        reg_wdata = ~reg_wdata;
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule

// *** tb/cacr_regs_bench.sv ***
// Bench for the auxiliary pin, clock source and attack registers.
// Assumes the host model owns the register port; pins come from here.
`timescale 1ns/10ps
module cacr_regs_bench;
    import cacr_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic bus_select = 1'b0;
    logic pin0 = 1'b0;
    logic pin1 = 1'b1;
    logic pin3 = 1'b0;
    logic [6:0] reg_addr;
    logic reg_wr, reg_rd, reg_hit, gp_out, gp_oe, sdi_en, gpi_en, core_sel;
    logic [7:0] reg_wdata, reg_rdata, atk_mul;
    logic [1:0] div_sel, pll_sel;
    logic [4:0] pll_n;
    logic atk_sel;
    logic [3:0] atk_ms;
    logic [3:0] ms [4] = '{4'h7, 4'h8, 4'hA, 4'hB};
    int n_errors = 0;
    int compares = 0;

    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    cacr_host host (.ref_clk(ref_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));

    cacr_regs dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit), .bus_select(bus_select),
        .multi_pin_zero_in(pin0), .multi_pin_one_in(pin1),
        .multi_pin_three_in(pin3), .multi_pin_two_out(gp_out),
        .multi_pin_two_oe(gp_oe), .audio_serial_in_en(sdi_en),
        .multi_pin_three_gpi_en(gpi_en), .core_clock_sel_div(core_sel),
        .clock_divider_input_sel(div_sel), .pll_input_clock_sel(pll_sel),
        .pll_divider_n(pll_n), .atk_from_new_reg(atk_sel),
        .atk_base_ms(atk_ms), .atk_multiplier(atk_mul));

    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    task automatic stop_test();
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic t_reset();
        logic [7:0] d;
        host.rd(CACR_AUX_PIN_ADDR, d);
        chk("aux", 8'h80, d);
        host.rd(CACR_CLK_SRC_ADDR, d);
        chk("clk", 8'h02, d);
        chk("n", 8'h02, {3'h0, pll_n});
        host.rd(CACR_AGC_ATK_ADDR, d);
        chk("atk", 8'h00, d);
        chk("hit", 8'h01, {7'h00, reg_hit});
        host.rd(7'h64, d);
        chk("unmapped", 8'h00, d);
        chk("hit", 8'h00, {7'h00, reg_hit});
    endtask

    task automatic t_aux();
        logic [7:0] d;
        host.wr(CACR_AUX_PIN_ADDR, 8'h37);
        chk("oe", 8'h01, {7'h00, gp_oe});
        chk("gpo", 8'h01, {7'h00, gp_out});
        chk("sdi", 8'h01, {7'h00, sdi_en});
        chk("gpi", 8'h01, {7'h00, gpi_en});
        chk("core", 8'h01, {7'h00, core_sel});
        // Straps move after reset; the address status bits must not follow, while bit 3 follows pin three
        pin3 = 1'b1;
        pin0 = 1'b1;
        pin1 = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        host.rd(CACR_AUX_PIN_ADDR, d);
        chk("aux", 8'hBF, d);
        pin3 = 1'b0;
        host.wr(CACR_AUX_PIN_ADDR, 8'h35);
        chk("gpo", 8'h00, {7'h00, gp_out});
        repeat (2) @(posedge ref_clk);
        #1;
        host.rd(CACR_AUX_PIN_ADDR, d);
        chk("aux", 8'hB5, d);
        bus_select = 1'b1;
        @(posedge ref_clk);
        #1;
        chk("oe", 8'h00, {7'h00, gp_oe});
        chk("gpo", 8'h00, {7'h00, gp_out});
        chk("sdi", 8'h00, {7'h00, sdi_en});
        chk("gpi", 8'h00, {7'h00, gpi_en});
        chk("core", 8'h01, {7'h00, core_sel});
        host.wr(CACR_AUX_PIN_ADDR, 8'h00);
        chk("core", 8'h00, {7'h00, core_sel});
        bus_select = 1'b0;
    endtask

    task automatic t_clk();
        logic [7:0] d;
        logic [7:0] q;
        logic [4:0] n;
        for (int i = 0; i < 16; i++)
        begin
            d = {2'(i % 3), 2'((i + 1) % 3), 4'(i)};
            n = (i == 0) ? 5'h10 : (i == 1) ? 5'h11 : 5'(i);
            host.wr(CACR_CLK_SRC_ADDR, d);
            chk("div", {6'h00, d[7:6]}, {6'h00, div_sel});
            chk("pll", {6'h00, d[5:4]}, {6'h00, pll_sel});
            chk("n", {3'h0, n}, {3'h0, pll_n});
            host.rd(CACR_CLK_SRC_ADDR, q);
            chk("clk", d, q);
        end
    endtask

    task automatic t_atk();
        logic [7:0] d;
        for (int b = 0; b < 4; b++)
        begin
            for (int m = 0; m < 8; m++)
            begin
                host.wr(CACR_AGC_ATK_ADDR, {1'b1, 2'(b), 3'(m), 2'b00});
                chk("sel", 8'h01, {7'h00, atk_sel});
                chk("base", {4'h0, ms[b]}, {4'h0, atk_ms});
                chk("mul", 8'h01 << m, atk_mul);
            end
        end
        host.rd(CACR_AGC_ATK_ADDR, d);
        chk("atk", 8'hFC, d);
        host.wr(CACR_AGC_ATK_ADDR, 8'h00);
        chk("sel", 8'h00, {7'h00, atk_sel});
    endtask

    task automatic t_rst2();
        logic [7:0] d;
        // Straps now show pin zero high and pin one low
        srst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        @(posedge ref_clk);
        #1;
        host.rd(CACR_AUX_PIN_ADDR, d);
        chk("aux", 8'h40, d);
        host.rd(CACR_CLK_SRC_ADDR, d);
        chk("clk", 8'h02, d);
    endtask

    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_aux();
        t_clk();
        t_atk();
        t_rst2();
        stop_test();
    end

    // About 180 cycles of traffic; this leaves wide margin
    initial
    begin
        #100000;
        n_errors++;
        stop_test();
    end
endmodule
